// >>> rtl/flash_self_program_sequencer.sv
/*
 Flash self-programming sequencer: control/status register, pointer
 decode, command arming, page buffer loads, page erase, page write and
 lock bit programming, with read-section blocking and core halt.
 Assumes the core gives a one-cycle store_exec pulse per store
 instruction and that all inputs come from logic on clk.
*/
// Behaviour
// - Pointer is extension, high, low bytes concatenated
// - Extension byte only used above 64 KB
// - Low pointer bits word, upper bits page
// - Page latched when an operation starts
// - Pointer bit zero picks byte on loads
// - Buffer words load in any order
// - Erase pattern then store within four cycles
// - Core halted only for no-concurrent-read target
// - Buffer load pattern stores data word
// - Buffer cleared after write, re-enable, reset
// - EEPROM write leaves buffer contents intact
// - Write pattern then store within four cycles
// - Interrupt held while enable bit clear and interrupt enable set
// - Read section blocked and busy during erase and write
// - Lock pattern programs bits zero in data
// - Whole flash readable during lock programming
// - EEPROM write blocks all self-programming
// - Armed command clears after four idle cycles
// - Boot lock refuses writes to protected section
// - Operation time from programming counter
`timescale 1ns/1ps
`include "fsp_cfg.svh"

module flash_self_program_sequencer #(
  parameter int PROG_CYCLES = `FSP_PROG_CYCLES // Clocks per operation
) (
  input wire logic clk, // Core clock, 100 MHz
  input wire logic nrst, // Async reset, low
  input wire logic csr_wr, // Control write strobe
  input wire logic [7:0] csr_wdata, // Control write data
  output logic [7:0] csr_rdata, // Control/status read
  input wire logic store_exec, // Store instruction, pulse
  input wire logic [7:0] pointer_extension_byte, // Pointer 23:16
  input wire logic [7:0] pointer_high_byte, // Pointer 15:8
  input wire logic [7:0] pointer_low_byte, // Pointer 7:0
  input wire logic [7:0] low_data_register, // Data low byte
  input wire logic [7:0] high_data_register, // Data high byte
  input wire logic eeprom_write_enable_status, // EEPROM busy
  output logic [`FSP_WADDR_W-1:0] load_word_addr, // Load word
  output logic load_byte_hi, // Load byte select
  output logic selfprog_irq, // Interrupt level
  output logic cpu_halt, // Halt the core
  output logic section_read_block, // Read section blocked
  output logic flash_erase, // Erase running
  output logic flash_write, // Page write running
  output logic flash_lock, // Lock write running
  output logic [`FSP_PAGE_W-1:0] flash_page, // Latched page
  output logic flash_done, // Operation finished, pulse
  input wire logic [`FSP_WIDX_W-1:0] buf_rd_idx, // Array read idx
  output logic [15:0] buf_rd_data, // Array read word
  output logic [`FSP_LOCK_W-1:0] lock_bits // Current lock bits
);

  //////////////////////////////////////////////////////////////////////
  // Constants and state

  // Small parts have no extension byte
  localparam bit HAS_EXT = `FSP_FLASH_KB > `FSP_SMALL_KB;

  // Command codes, order {sig read, lock, write, erase}
  localparam logic [3:0] CMD_LOAD = 4'h0;
  localparam logic [3:0] CMD_ERASE = 4'h1;
  localparam logic [3:0] CMD_WRITE = 4'h2;
  localparam logic [3:0] CMD_LOCK = 4'h4;

  fsp_pkg::seq_s r, n; // Registered state and next

  logic [`FSP_PTR_W-1:0] ptr; // Full pointer
  logic [7:0] ext_used; // Extension byte as used
  logic [`FSP_PAGE_W-1:0] ptr_page; // Page index field
  logic [`FSP_WIDX_W-1:0] ptr_widx; // Word index field
  logic csr_ok; // Accepted control write
  logic arm; // Control write arms a command
  logic reen; // Control write re-enables read section
  logic go; // Store lands in the arm window
  logic timeout; // Arm window ran out
  logic tgt_boot; // Page in boot loader section
  logic tgt_ncr; // Page in no-concurrent-read section
  logic forbid; // Boot lock refuses the write
  logic load_go; // Buffer word load now
  logic prog_go; // Long operation starts now
  logic tmr_done; // Programming time elapsed
  logic [3:0] wcmd; // Command field of write data

  page_buf_if pb (); // Buffer link

  //////////////////////////////////////////////////////////////////////
  // Pointer decode

  // Extension byte tied off on small parts
  assign ext_used = HAS_EXT ? pointer_extension_byte : 8'h00;

  // Full 24-bit pointer
  assign ptr = {ext_used, pointer_high_byte, pointer_low_byte};

  // Word within page, page above it
  assign ptr_widx = ptr[`FSP_WIDX_MSB:`FSP_WIDX_LSB];
  assign ptr_page = ptr[`FSP_PAGE_MSB:`FSP_PAGE_LSB];

  // Byte loads use bit zero as the byte select
  assign load_word_addr = ptr[`FSP_PAGE_MSB:`FSP_WIDX_LSB];
  assign load_byte_hi = ptr[0];

  // Section of the addressed page
  assign tgt_boot = ptr_page >= `FSP_BOOT_PAGE;
  assign tgt_ncr = ptr_page >= `FSP_NCR_PAGE;

  // A programmed (zero) write-lock bit refuses the section
  assign forbid = tgt_boot ? ~r.lock_r[`FSP_BOOT_WLOCK_BIT]
                           : ~r.lock_r[`FSP_APP_WLOCK_BIT];

  //////////////////////////////////////////////////////////////////////
  // Control write and store decode

  // Command field of the written value
  assign wcmd = {csr_wdata[`FSP_SIGRD_BIT], csr_wdata[`FSP_LOCK_BIT],
                 csr_wdata[`FSP_WRITE_BIT], csr_wdata[`FSP_ERASE_BIT]};

  // EEPROM write or running operation locks the register out
  assign csr_ok = csr_wr && !eeprom_write_enable_status
                  && r.st != fsp_pkg::st_busy;

  // Re-enable acts at once; everything else waits for a store
  assign reen = csr_ok && csr_wdata[`FSP_EN_BIT]
                && csr_wdata[`FSP_REEN_BIT];
  assign arm = csr_ok && csr_wdata[`FSP_EN_BIT]
               && !csr_wdata[`FSP_REEN_BIT];

  // Store counts while armed and no EEPROM write runs
  assign go = r.st == fsp_pkg::st_armed && store_exec
              && !eeprom_write_enable_status
              && r.arm_cnt < `FSP_ARM_CYCLES;

  // Last cycle of the window passed without a store
  assign timeout = r.st == fsp_pkg::st_armed && !go
                   && r.arm_cnt == `FSP_ARM_CYCLES - 3'h1;

  // Buffer word load
  assign load_go = go && r.cmd == CMD_LOAD;

  // Erase and write checked against boot lock; lock always allowed
  assign prog_go = go && (((r.cmd == CMD_ERASE || r.cmd == CMD_WRITE)
                           && !forbid) || r.cmd == CMD_LOCK);

  //////////////////////////////////////////////////////////////////////
  // Page buffer

  // Load writes the data word at the word index
  assign pb.wr = load_go;
  assign pb.wr_idx = ptr_widx;
  assign pb.wr_data = {high_data_register, low_data_register};

  // Cleared after a page write and on re-enable; EEPROM activity
  // never reaches the clear, so a half-loaded page survives it
  assign pb.clr = reen
                  || (tmr_done && r.op == fsp_pkg::op_write);
  assign pb.rd_idx = buf_rd_idx;
  assign buf_rd_data = pb.rd_data;

  page_buffer u_buf (
    .clk(clk),
    .nrst(nrst),
    .bus(pb.buffer)
  );

  //////////////////////////////////////////////////////////////////////
  // Programming timer

  prog_timer #(
    .CYCLES(PROG_CYCLES)
  ) u_tmr (
    .clk(clk),
    .nrst(nrst),
    .start(prog_go),
    .done(tmr_done)
  );

  //////////////////////////////////////////////////////////////////////
  // Sequencer next state
  always_comb
  begin
    n = r;
    n.done = 1'b0;

    // Interrupt enable follows any accepted control write
    if (csr_ok)
      n.ie = csr_wdata[`FSP_IE_BIT];

    // Re-enable clears busy; a start in the same cycle sets it again
    if (reen)
      n.rs_busy = 1'b0;

    unique case (r.st)
      fsp_pkg::st_idle:
      begin
        // Arm and open the four-cycle window
        if (arm)
        begin
          n.st = fsp_pkg::st_armed;
          n.cmd = wcmd;
          n.en = 1'b1;
          n.arm_cnt = 3'h0;
        end
      end

      fsp_pkg::st_armed:
      begin
        n.arm_cnt = r.arm_cnt + 3'h1;
        if (prog_go)
        begin
          // Latch address and data; pointer is free from here on
          n.st = fsp_pkg::st_busy;
          n.page = ptr_page;
          n.ncr = tgt_ncr;
          n.lock_data = low_data_register[`FSP_LOCK_W-1:0];
          n.en = 1'b1;
          unique case (r.cmd)
            CMD_ERASE:
            begin
              n.op = fsp_pkg::op_erase;
              n.rs_busy = 1'b1;
            end
            CMD_WRITE:
            begin
              n.op = fsp_pkg::op_write;
              n.rs_busy = 1'b1;
            end
            default:
              // Lock write leaves the read section open
              n.op = fsp_pkg::op_lock;
          endcase
        end
        else if (go)
        begin
          // Load, refused write or unknown pattern: done at once
          n.st = fsp_pkg::st_idle;
          n.en = 1'b0;
          n.cmd = 4'h0;
        end
        else if (arm)
        begin
          // Rewrite restarts the window
          n.cmd = wcmd;
          n.arm_cnt = 3'h0;
        end
        else if (timeout)
        begin
          // Window lapsed: drop the command
          n.st = fsp_pkg::st_idle;
          n.en = 1'b0;
          n.cmd = 4'h0;
        end
        else if (csr_ok)
        begin
          // Write without enable bit cancels
          n.st = fsp_pkg::st_idle;
          n.en = 1'b0;
          n.cmd = 4'h0;
        end
      end

      fsp_pkg::st_busy:
      begin
        // Hold the enable bit until time is up
        if (tmr_done)
        begin
          n.st = fsp_pkg::st_idle;
          n.en = 1'b0;
          n.cmd = 4'h0;
          n.op = fsp_pkg::op_none;
          n.done = 1'b1;
          // Programming only clears lock bits, never sets them
          if (r.op == fsp_pkg::op_lock)
            n.lock_r = r.lock_r & r.lock_data;
        end
      end

      default:
        // Illegal code: fall back to idle, drop command
        begin
          n.st = fsp_pkg::st_idle;
          n.en = 1'b0;
          n.cmd = 4'h0;
          n.op = fsp_pkg::op_none;
        end
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  // Sequencer state register
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      r <= '0;
      r.st <= fsp_pkg::st_idle;
      r.op <= fsp_pkg::op_none;
      r.lock_r <= `FSP_LOCK_RESET;
    end
    else
      r <= n;
  end

  //////////////////////////////////////////////////////////////////////
  // Outputs

  // Status read; re-enable bit always reads zero
  assign csr_rdata = {r.ie, r.rs_busy, r.cmd[3], 1'b0,
                      r.cmd[2], r.cmd[1], r.cmd[0], r.en};

  // Level interrupt whenever interrupt enable is set and the enable bit is low
  assign selfprog_irq = r.ie && !r.en;

  // Halt only for erase/write aimed at the no-concurrent section
  assign cpu_halt = r.st == fsp_pkg::st_busy && r.ncr
                    && r.op != fsp_pkg::op_lock;

  // Busy flag stays until re-enabled, so reads stay blocked
  assign section_read_block = r.rs_busy;

  // Operation levels toward the array
  assign flash_erase = r.op == fsp_pkg::op_erase;
  assign flash_write = r.op == fsp_pkg::op_write;
  assign flash_lock = r.op == fsp_pkg::op_lock;
  assign flash_page = r.page;
  assign flash_done = r.done;
  assign lock_bits = r.lock_r;

endmodule

// >>> rtl/fsp_cfg.svh
/*
 Constants of the flash self-programming sequencer: pointer layout,
 control/status field positions, reset values and timing counts.
 Assumes a 100 MHz core clock and a 256 KB program flash.
*/
`ifndef FSP_CFG_SVH
`define FSP_CFG_SVH

// Pointer and flash geometry
`define FSP_PTR_W 24
`define FSP_FLASH_KB 256
`define FSP_SMALL_KB 64
`define FSP_WIDX_W 7
`define FSP_PAGE_W 10
`define FSP_WADDR_W 17
`define FSP_WIDX_LSB 1
`define FSP_WIDX_MSB 7
`define FSP_PAGE_LSB 8
`define FSP_PAGE_MSB 17
`define FSP_PAGE_WORDS 128
// First page of the no-concurrent-read and boot loader sections
`define FSP_NCR_PAGE 10'h3e0
`define FSP_BOOT_PAGE 10'h3e0

// Control/status field positions
`define FSP_EN_BIT 0
`define FSP_ERASE_BIT 1
`define FSP_WRITE_BIT 2
`define FSP_LOCK_BIT 3
`define FSP_REEN_BIT 4
`define FSP_SIGRD_BIT 5
`define FSP_BUSY_BIT 6
`define FSP_IE_BIT 7

// Lock bits: 1 is unprogrammed
`define FSP_LOCK_W 6
`define FSP_LOCK_RESET 6'h3f
`define FSP_APP_WLOCK_BIT 2
`define FSP_BOOT_WLOCK_BIT 4

// Timing
`define FSP_ARM_CYCLES 3'h4
`define FSP_CLK_PERIOD_NS 10
`define FSP_T_PROG_MIN_US 3700
`define FSP_T_PROG_MAX_US 4500
`define FSP_PROG_CYCLES ((`FSP_T_PROG_MIN_US * 1000 + `FSP_CLK_PERIOD_NS - 1) / `FSP_CLK_PERIOD_NS)
`define FSP_TMR_W 19

`endif

// >>> rtl/fsp_pkg.sv
/*
 Types of the flash self-programming sequencer.
 Assumes fsp_cfg.svh for all widths.
*/
`include "fsp_cfg.svh"

package fsp_pkg;
  // Sequencer states, one-hot
  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_armed = 3'b010,
    st_busy = 3'b100
  } seq_state_e;

  // Long operation kinds, one-hot
  typedef enum logic [2:0] {
    op_none = 3'b000,
    op_erase = 3'b001,
    op_write = 3'b010,
    op_lock = 3'b100
  } op_kind_e;

  // Whole state of the sequencer
  typedef struct packed {
    seq_state_e st;
    logic ie;
    logic rs_busy;
    logic [3:0] cmd;
    logic en;
    logic [2:0] arm_cnt;
    op_kind_e op;
    logic [`FSP_PAGE_W-1:0] page;
    logic ncr;
    logic [`FSP_LOCK_W-1:0] lock_r;
    logic [`FSP_LOCK_W-1:0] lock_data;
    logic done;
  } seq_s;

  // Timer state
  typedef struct packed {
    logic run;
    logic [`FSP_TMR_W-1:0] cnt;
    logic done;
  } tmr_s;
endpackage

// >>> rtl/page_buf_if.sv
/*
 Link between the sequencer and its temporary page buffer.
 Assumes a single clock shared by both ends.
*/
`timescale 1ns/1ps
`include "fsp_cfg.svh"

interface page_buf_if;
  logic clr; // Clear whole buffer
  logic wr; // Write one word
  logic [`FSP_WIDX_W-1:0] wr_idx; // Word index of write
  logic [15:0] wr_data; // Word to write
  logic [`FSP_WIDX_W-1:0] rd_idx; // Word index of read
  logic [15:0] rd_data; // Registered read word
  modport ctrl (output clr, wr, wr_idx, wr_data, rd_idx, input rd_data);
  modport buffer (input clr, wr, wr_idx, wr_data, rd_idx, output rd_data);
endinterface

// >>> rtl/page_buffer.sv
/*
 Temporary page buffer, one flip-flop word per page entry.
 Assumes the controller never clears and writes the same cycle by intent;
 if it does, the write wins for its entry.
*/
`timescale 1ns/1ps
`include "fsp_cfg.svh"

module page_buffer (
  input wire logic clk, // Core clock
  input wire logic nrst, // Async reset, low
  page_buf_if.buffer bus // Controller link
);
  typedef struct packed {
    logic [`FSP_PAGE_WORDS-1:0][15:0] mem;
    logic [15:0] rd;
  } buf_s;

  buf_s r, n;
  logic [`FSP_PAGE_WORDS-1:0][15:0] mem_nxt; // Per-entry next value

  //////////////////////////////////////////////////////////////////////
  // Any word order is accepted: each entry decodes its own index
  generate
    for (genvar i = 0; i < `FSP_PAGE_WORDS; i++)
    begin : g_ent
      assign mem_nxt[i] =
        (bus.wr && bus.wr_idx == `FSP_WIDX_W'(i)) ? bus.wr_data :
        bus.clr ? 16'h0000 : r.mem[i];
    end
  endgenerate

  // Next state
  always_comb
  begin
    n = r;
    n.mem = mem_nxt;
    n.rd = r.mem[bus.rd_idx];
  end

  // Reset empties the buffer
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      r <= '0;
    else
      r <= n;
  end

  assign bus.rd_data = r.rd;
endmodule

// >>> rtl/prog_timer.sv
/*
 Programming-time counter for erase, write and lock operations.
 Assumes start is a one-cycle pulse given only while idle.
*/
`timescale 1ns/1ps
`include "fsp_cfg.svh"

module prog_timer #(
  parameter int CYCLES = `FSP_PROG_CYCLES // Operation length
) (
  input wire logic clk, // Core clock
  input wire logic nrst, // Async reset, low
  input wire logic start, // Begin timing, pulse
  output logic done // Time elapsed, pulse
);
  localparam logic [`FSP_TMR_W-1:0] LAST = `FSP_TMR_W'(CYCLES - 1);

  fsp_pkg::tmr_s r, n;

  //////////////////////////////////////////////////////////////////////
  // Count CYCLES clocks from the start pulse
  always_comb
  begin
    n = r;
    n.done = 1'b0;
    if (start)
    begin
      n.run = 1'b1;
      n.cnt = '0;
    end
    else if (r.run)
    begin
      if (r.cnt == LAST)
      begin
        n.run = 1'b0;
        n.done = 1'b1;
      end
      else
        n.cnt = r.cnt + 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      r <= '0;
    else
      r <= n;
  end

  assign done = r.done;
endmodule

// >>> sim/core_model.sv
/*
 Core model: control writes, store instructions, pointer and
 data registers. Assumes the bench calls its tasks in sequence.
*/
`timescale 1ns/1ps

module core_model (
  input wire logic clk, // Core clock
  input wire logic eeprom_write_enable_status, // EEPROM busy
  output logic csr_wr, // Control write
  output logic [7:0] csr_wdata, // Control data
  output logic store_exec, // Store pulse
  output logic [23:0] ptr, // Pointer bytes
  output logic [15:0] data // Data word
);
  initial
  begin
    csr_wr = 1'b0;
    csr_wdata = 8'h00;
    store_exec = 1'b0;
    ptr = 24'h0;
    data = 16'h0;
  end
  // Registers hold their value, like a register file
  task automatic set_regs(input logic [23:0] p, input logic [15:0] d);
    @(posedge clk);
    ptr <= p;
    data <= d;
  endtask
  // Raw skips the EEPROM check, to provoke a refusal
  task automatic csr_write(input logic [7:0] v, input bit raw);
    while (eeprom_write_enable_status && !raw)
      @(posedge clk);
    @(posedge clk);
    csr_wr <= 1'b1;
    csr_wdata <= v;
    @(posedge clk);
    csr_wr <= 1'b0;
  endtask
  // Store lands gap cycles after the write edge
  task automatic spm(input logic [7:0] v, input int gap, input bit raw);
    csr_write(v, raw);
    repeat (gap - 1) @(posedge clk);
    store_exec <= 1'b1;
    @(posedge clk);
    store_exec <= 1'b0;
  endtask
endmodule

// >>> sim/flash_self_program_sequencer_bench.sv
/*
 Self-checking sequencer bench.
 Assumes core_model drives the core; operations last 21 clocks.
*/
`timescale 1ns/1ps
`include "fsp_cfg.svh"

module flash_self_program_sequencer_bench;
  logic clk, nrst, ee, csr_wr, store_exec, load_byte_hi, selfprog_irq;
  logic cpu_halt, section_read_block, flash_erase, flash_write;
  logic flash_lock, flash_done;
  logic [7:0] csr_wdata, csr_rdata;
  logic [23:0] ptr;
  logic [15:0] data, buf_rd_data, rv;
  logic [16:0] load_word_addr;
  logic [9:0] flash_page;
  logic [6:0] buf_rd_idx;
  logic [5:0] lock_bits;
  int error_cnt = 0;
  int check_count = 0;
  core_model i_core (.clk(clk), .eeprom_write_enable_status(ee),
    .csr_wr(csr_wr), .csr_wdata(csr_wdata), .store_exec(store_exec),
    .ptr(ptr), .data(data));
  flash_self_program_sequencer #(.PROG_CYCLES(20)) i_dut (.clk(clk),
    .nrst(nrst), .csr_wr(csr_wr), .csr_wdata(csr_wdata),
    .csr_rdata(csr_rdata), .store_exec(store_exec),
    .pointer_extension_byte(ptr[23:16]), .pointer_high_byte(ptr[15:8]),
    .pointer_low_byte(ptr[7:0]), .low_data_register(data[7:0]),
    .high_data_register(data[15:8]), .eeprom_write_enable_status(ee),
    .load_word_addr(load_word_addr), .load_byte_hi(load_byte_hi),
    .selfprog_irq(selfprog_irq), .cpu_halt(cpu_halt),
    .section_read_block(section_read_block), .flash_erase(flash_erase),
    .flash_write(flash_write), .flash_lock(flash_lock),
    .flash_page(flash_page), .flash_done(flash_done),
    .buf_rd_idx(buf_rd_idx), .buf_rd_data(buf_rd_data),
    .lock_bits(lock_bits));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [23:0] pa(input logic [9:0] p,
    input logic [6:0] w);
    return {6'h00, p, w, 1'b0};
  endfunction
  // Buffer read has one cycle of latency
  task automatic rd_buf(input logic [6:0] idx);
    @(posedge clk);
    buf_rd_idx <= idx;
    @(posedge clk);
    #1;
    rv = buf_rd_data;
  endtask
  // Bounded wait; ends in the done cycle
  task automatic wait_done();
    int n = 0;
    while (flash_done !== 1'b1 && n < 100)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(n < 100, 1);
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset_ptr();
    chk(csr_rdata, 8'h00);
    chk(lock_bits, 6'h3f);
    chk(selfprog_irq, 1'b0);
    i_core.set_regs(24'h023457, 16'h0000);
    #1;
    chk(load_word_addr, 17'h11a2b);
    chk(load_byte_hi, 1'b1);
    $display("test reset_ptr done");
  endtask
  // Out-of-order loads, then one refused by an EEPROM write
  task automatic t_load();
    i_core.set_regs(pa(10'h005, 7'h05), 16'ha5a5);
    i_core.spm(8'h01, 2, 0);
    i_core.set_regs(pa(10'h005, 7'h02), 16'h1234);
    i_core.spm(8'h01, 1, 0);
    rd_buf(7'h05);
    chk(rv, 16'ha5a5);
    rd_buf(7'h02);
    chk(rv, 16'h1234);
    @(posedge clk);
    ee <= 1'b1;
    i_core.set_regs(pa(10'h005, 7'h09), 16'hffff);
    i_core.spm(8'h01, 1, 1);
    ee <= 1'b0;
    #1;
    chk(csr_rdata, 8'h00);
    rd_buf(7'h09);
    chk(rv, 16'h0000);
    rd_buf(7'h05);
    chk(rv, 16'ha5a5);
    $display("test load done");
  endtask
  // Erase, store on the last window cycle
  task automatic t_erase();
    i_core.set_regs(pa(10'h005, 7'h00), 16'h0000);
    i_core.spm(8'h03, 4, 0);
    #1;
    chk(flash_erase, 1'b1);
    chk(section_read_block, 1'b1);
    chk(cpu_halt, 1'b0);
    i_core.set_regs(pa(10'h3ff, 7'h00), 16'h0000);
    #1;
    chk(flash_page, 10'h005);
    chk(csr_rdata[0], 1'b1);
    wait_done();
    chk(csr_rdata[0], 1'b0);
    rd_buf(7'h05);
    chk(rv, 16'ha5a5);
    $display("test erase done");
  endtask
  task automatic t_write();
    i_core.set_regs(pa(10'h005, 7'h00), 16'h0000);
    i_core.spm(8'h05, 1, 0);
    #1;
    chk(flash_write, 1'b1);
    wait_done();
    rd_buf(7'h05);
    chk(rv, 16'h0000);
    chk(csr_rdata[6], 1'b1);
    i_core.csr_write(8'h11, 0);
    #1;
    chk(csr_rdata[6], 1'b0);
    $display("test write done");
  endtask
  // No-concurrent-read target; re-enable empties buffer
  task automatic t_ncr();
    i_core.set_regs(pa(10'h3e0, 7'h03), 16'h0077);
    i_core.spm(8'h01, 1, 0);
    i_core.spm(8'h03, 1, 0);
    #1;
    chk(cpu_halt, 1'b1);
    wait_done();
    i_core.csr_write(8'h11, 0);
    #1;
    chk(section_read_block, 1'b0);
    rd_buf(7'h03);
    chk(rv, 16'h0000);
    $display("test ncr done");
  endtask
  task automatic t_refusals();
    i_core.spm(8'h03, 5, 0);
    #1;
    chk(flash_erase, 1'b0);
    chk(csr_rdata, 8'h00);
    i_core.spm(8'h27, 1, 0);
    #1;
    chk(flash_erase | flash_write | flash_lock, 1'b0);
    $display("test refusals done");
  endtask
  // Lock the application section, then try to erase it
  task automatic t_lock();
    i_core.set_regs(24'h000001, 16'h00fb);
    i_core.spm(8'h09, 1, 0);
    #1;
    chk(flash_lock, 1'b1);
    chk(section_read_block, 1'b0);
    chk(cpu_halt, 1'b0);
    wait_done();
    chk(lock_bits, 6'h3b);
    i_core.set_regs(pa(10'h005, 7'h00), 16'h0000);
    i_core.spm(8'h03, 1, 0);
    #1;
    chk(flash_erase, 1'b0);
    @(posedge clk);
    #1;
    chk(csr_rdata[0], 1'b0);
    $display("test lock done");
  endtask
  task automatic t_irq();
    i_core.csr_write(8'h80, 0);
    #1;
    chk(selfprog_irq, 1'b1);
    i_core.csr_write(8'h81, 0);
    #1;
    chk(selfprog_irq, 1'b0);
    repeat (5) @(posedge clk);
    #1;
    chk(selfprog_irq, 1'b1);
    $display("test irq done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Watchdog: the tests need under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    print_verdict();
  end
  initial
  begin
    nrst = 1'b0;
    ee = 1'b0;
    buf_rd_idx = 7'h00;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1;
    t_reset_ptr();
    t_load();
    t_erase();
    t_write();
    t_ncr();
    t_refusals();
    t_lock();
    t_irq();
    print_verdict();
  end
endmodule

// >>> sim/fsp_checker.sv
/*
 Sequencer port assertions.
 Assumes one clock and an async active-low reset.
*/
`timescale 1ns/1ps
`include "fsp_cfg.svh"

module fsp_checker #(
  parameter int PROG_CYCLES = 20 // Clocks per operation
) (
  input wire logic clk, // Core clock
  input wire logic nrst, // Reset, low
  input wire logic csr_wr, // Control write
  input wire logic [7:0] csr_wdata, // Control data
  input wire logic [7:0] csr_rdata, // Status
  input wire logic store_exec, // Store pulse
  input wire logic eeprom_write_enable_status, // EEPROM busy
  input wire logic selfprog_irq, // Interrupt
  input wire logic cpu_halt, // Core halt
  input wire logic section_read_block, // Read block
  input wire logic flash_erase, // Erase running
  input wire logic flash_write, // Write running
  input wire logic flash_lock, // Lock running
  input wire logic [`FSP_PAGE_W-1:0] flash_page, // Latched page
  input wire logic flash_done, // Done pulse
  input wire logic [`FSP_LOCK_W-1:0] lock_bits // Lock bits
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!nrst);
  logic ops; // Operation running
  logic ee; // Short alias
  logic [31:0] len_r; // Cycles in the operation
  logic [31:0] len_nxt;
  assign ops = flash_erase | flash_write | flash_lock;
  assign ee = eeprom_write_enable_status;
  // Length counter; too long to repeat
  always_comb len_nxt = ops ? len_r + 32'h1 : 32'h0;
  always_ff @(posedge clk or negedge nrst)
    if (!nrst) len_r <= 32'h0;
    else len_r <= len_nxt;
  ////////////////////////////////////////////////////////////////////////
  a_irq_level:
    assert property (selfprog_irq == (csr_rdata[7] && !csr_rdata[0]))
    else $error("interrupt level wrong");
  a_busy_flag:
    assert property ($fell(section_read_block) |->
      $past(csr_wr && csr_wdata[4] && csr_wdata[0]))
    else $error("block cleared without re-enable");
  a_op_busy:
    assert property ($rose(flash_erase | flash_write) |-> section_read_block)
    else $error("no read block");
  a_en_held:
    assert property (ops |-> csr_rdata[0])
    else $error("enable dropped");
  a_done_end:
    assert property (flash_done |-> !csr_rdata[0] && !ops && $past(ops))
    else $error("stray done pulse");
  a_op_len:
    assert property ($fell(ops) |-> len_r == PROG_CYCLES + 1)
    else $error("bad op length");
  a_halt_ncr:
    assert property ((flash_erase | flash_write) &&
      flash_page >= `FSP_NCR_PAGE |-> cpu_halt)
    else $error("core not halted");
  a_lock_read:
    assert property (flash_lock |-> !cpu_halt)
    else $error("halt during lock");
  a_lock_chg:
    assert property ($changed(lock_bits) |-> $past(flash_lock) &&
      (lock_bits & ~$past(lock_bits)) == 6'h00)
    else $error("stray lock change");
  a_arm_expire:
    assert property (csr_wr && csr_wdata == 8'h03 && !ee && !ops
      ##1 (!store_exec && !csr_wr) [*4] |=> csr_rdata[3:0] == 4'h0)
    else $error("arm did not expire");
  a_erase_late:
    assert property (csr_wr && csr_wdata == 8'h03 && !ee && !ops &&
      lock_bits == 6'h3f ##1 (!csr_wr && !store_exec) [*3]
      ##1 (store_exec && !ee) |=> flash_erase)
    else $error("late store refused");
  a_write_go:
    assert property (csr_wr && csr_wdata == 8'h05 && !ee && !ops &&
      lock_bits == 6'h3f ##1 (store_exec && !ee) |=> flash_write)
    else $error("write not started");
  a_unknown:
    assert property (store_exec && csr_rdata[0] && !ops &&
      !(csr_rdata[3:0] inside {4'h1, 4'h3, 4'h5, 4'h9}) |=> !ops)
    else $error("unknown command ran");
  a_ee_block:
    assert property ($rose(ops) |-> !$past(ee))
    else $error("op during EEPROM write");
endmodule

bind flash_self_program_sequencer fsp_checker #(
  .PROG_CYCLES(PROG_CYCLES)
) i_chk (.clk(clk), .nrst(nrst), .csr_wr(csr_wr), .csr_wdata(csr_wdata),
  .csr_rdata(csr_rdata), .store_exec(store_exec),
  .eeprom_write_enable_status(eeprom_write_enable_status),
  .selfprog_irq(selfprog_irq), .cpu_halt(cpu_halt),
  .section_read_block(section_read_block), .flash_erase(flash_erase),
  .flash_write(flash_write), .flash_lock(flash_lock),
  .flash_page(flash_page), .flash_done(flash_done), .lock_bits(lock_bits));
